//--- design/analog_comparator_control.sv
`timescale 1ns/1ns
`include "acmp_regs.svh"
module analog_comparator_control (
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   input  wire logic [`ACMP_ADDR_W-1:0]  address,
   input  wire logic                     read,
   input  wire logic                     write,
   input  wire logic [31:0]              writedata,
   input  wire logic [3:0]               byteenable,
   output logic      [31:0]              readdata,
   output logic                          waitrequest,
   input  wire logic [`ACMP_NCOMP-1:0]   rawResult,
   input  wire logic                     smallPackage,
   input  wire logic [`ACMP_NCOMP-1:0]   portDirection,
   output logic      [`ACMP_NCOMP-1:0]   compEnable,
   output logic      [`ACMP_NCOMP-1:0]   posRefSelect,
   output logic [`ACMP_NCOMP*`ACMP_NROUTE-1:0] negRoute,
   output logic      [`ACMP_NCOMP-1:0]   pinSelect,
   output logic      [`ACMP_NCOMP-1:0]   pinValue,
   output logic      [`ACMP_NCOMP-1:0]   pinDrive,
   output logic      [`ACMP_NCOMP-1:0]   eventFlag
);
   localparam logic [`ACMP_ADDR_W-1:0] CTRL_OFS [`ACMP_NCOMP] =
      '{`ACMP_OFS_CTRL1, `ACMP_OFS_CTRL2, `ACMP_OFS_CTRL3};

   logic [7:0]               ctrl [`ACMP_NCOMP];
   logic [7:0]               next_ctrl [`ACMP_NCOMP];
   logic [`ACMP_NCOMP:0]     syncIn;
   logic [`ACMP_NCOMP:0]     syncOut;
   logic                     smallPkg;
   logic [`ACMP_NCOMP-1:0]   result;
   logic [`ACMP_NCOMP-1:0]   evtPulse;
   logic [`ACMP_NCOMP-1:0]   ctrlHit;
   logic [`ACMP_NCOMP-1:0]   anyArm;
   logic [`ACMP_NCOMP-1:0]   oeBits;
   logic                     rdReq;
   logic                     wrAcc;
   logic                     next_waitrequest;
   logic [31:0]              next_readdata;
   logic [`ACMP_NCOMP-1:0]   next_eventFlag;
   logic [`ACMP_NCOMP-1:0]   next_pinDrive;

   // strap is static but still comes from a pin
   assign syncIn = {smallPackage, rawResult};

   acmp_sync #(
      .WIDTH (`ACMP_NCOMP + 1)
   ) u_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .din     (syncIn),
      .dout    (syncOut)
   );

   assign smallPkg = syncOut[`ACMP_NCOMP];

   // one wait state: request seen, then answered next edge
   assign rdReq = read & waitrequest;
   assign wrAcc = write & ~waitrequest & byteenable[0];

   for (genvar i = 0; i < `ACMP_NCOMP; i++) begin : g_cmp
      logic [`ACMP_NROUTE-1:0] route;
      logic [`ACMP_NROUTE-1:0] next_route;
      acmp_pkg::neg_sel_t      neg;
      logic                    missing;

      assign ctrlHit[i] = wrAcc & (address == CTRL_OFS[i]);
      assign anyArm[i] = ctrlHit[i] &
         (writedata[`ACMP_EVT_HI:`ACMP_EVT_LO] == acmp_pkg::EDGE_ANY); // RL5
      assign oeBits[i] = ctrl[i][`ACMP_BIT_OE];
      assign compEnable[i] = ctrl[i][`ACMP_BIT_EN]; // RL1
      assign pinSelect[i] = ctrl[i][`ACMP_BIT_OE]; // RL2
      assign posRefSelect[i] = ctrl[i][`ACMP_BIT_REF]; // RL6
      assign negRoute[i*`ACMP_NROUTE +: `ACMP_NROUTE] = route;

      always_comb begin
         next_ctrl[i] = ctrlHit[i] ? writedata[7:0] : ctrl[i];
         neg = acmp_pkg::neg_sel_t'(ctrl[i][`ACMP_NEG_HI:`ACMP_NEG_LO]);
         // pins c of one and two, and the extra pin, are absent
         if (i == `ACMP_CMP_ONE) begin
            missing = smallPkg & (neg == acmp_pkg::NEG_PIN_C); // RL9
         end else if (i == `ACMP_CMP_TWO) begin
            missing = smallPkg & ((neg == acmp_pkg::NEG_PIN_C) |
                                  (neg == acmp_pkg::NEG_SHARED)); // RL9
         end else begin
            missing = 1'b0;
         end
         next_route = '0;
         unique case (neg) // RL7
            acmp_pkg::NEG_PIN_B:
               next_route[`ACMP_RT_PIN_B] = 1'b1;
            acmp_pkg::NEG_PIN_C:
               next_route[`ACMP_RT_PIN_C] = 1'b1;
            acmp_pkg::NEG_SHARED:
               if (i == `ACMP_CMP_TWO) begin
                  next_route[`ACMP_RT_EXTRA] = 1'b1; // RL8
               end else begin
                  next_route[`ACMP_RT_SHARED] = 1'b1; // RL8
               end
            acmp_pkg::NEG_BANDGAP:
               next_route[`ACMP_RT_BANDGAP] = 1'b1;
         endcase
         // an off comparator leaves every input switch open
         if (!ctrl[i][`ACMP_BIT_EN] || missing) begin
            next_route = '0; // RL1 RL9
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!rstn) begin
            ctrl[i] <= `ACMP_CTRL_RST; // RL13
            route   <= '0;
         end else begin
            ctrl[i] <= next_ctrl[i];
            route   <= next_route;
         end
      end

      acmp_event u_evt (
         .sys_clk    (sys_clk),
         .rstn       (rstn),
         .syncResult (syncOut[i]),
         .enable     (ctrl[i][`ACMP_BIT_EN]),
         .invert     (ctrl[i][`ACMP_BIT_POL]),
         .edgeSel    (acmp_pkg::edge_sel_t'(
                        ctrl[i][`ACMP_EVT_HI:`ACMP_EVT_LO])),
         .result     (result[i]),
         .evtPulse   (evtPulse[i])
      );
   end

   assign pinValue = result; // RL2 RL3

   always_comb begin
      next_waitrequest = ~((read | write) & waitrequest);
      next_readdata = readdata;
      if (rdReq) begin
         next_readdata = '0;
         case (address)
            `ACMP_OFS_CTRL1:
               next_readdata[7:0] = ctrl[0];
            `ACMP_OFS_CTRL2:
               next_readdata[7:0] = ctrl[1];
            `ACMP_OFS_CTRL3:
               next_readdata[7:0] = ctrl[2];
            `ACMP_OFS_STATUS:
               next_readdata[7:0] = {result, `ACMP_STAT_PAD}; // RL10 RL11
            `ACMP_OFS_FLAGS:
               next_readdata[`ACMP_NCOMP-1:0] = eventFlag;
            default:
               next_readdata = '0;
         endcase
      end
   end

   always_comb begin
      next_eventFlag = eventFlag;
      if (wrAcc && address == `ACMP_OFS_FLAGS) begin
         next_eventFlag = writedata[`ACMP_NCOMP-1:0]; // RL15
      end
      // hardware set wins over a same-cycle clear
      next_eventFlag = next_eventFlag | evtPulse | anyArm; // RL4 RL5 RL15
      next_pinDrive = oeBits & ~portDirection; // RL2 RL16
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         waitrequest <= 1'b1;
         readdata    <= '0;
         eventFlag   <= `ACMP_FLAG_RST;
         pinDrive    <= '0;
      end else begin
         waitrequest <= next_waitrequest;
         readdata    <= next_readdata;
         eventFlag   <= next_eventFlag;
         pinDrive    <= next_pinDrive;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   chk_bus_answer: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait cycle");

   chk_bus_release: assert property (
      !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   chk_ctrl_reset: assert property ( // RL13
      $rose(rstn) |-> ctrl[0] == `ACMP_CTRL_RST &&
         ctrl[1] == `ACMP_CTRL_RST && ctrl[2] == `ACMP_CTRL_RST)
      else $error("control not cleared by reset");

   chk_enable_write: assert property ( // RL1
      wrAcc && address == `ACMP_OFS_CTRL1
      |=> compEnable[0] == $past(writedata[`ACMP_BIT_EN]))
      else $error("enable bit not taken from write");

   chk_any_sets_flag: assert property ( // RL5
      anyArm[0] |=> eventFlag[0])
      else $error("any-change write did not set flag");

   chk_flag_sticky: assert property ( // RL15
      eventFlag[0] && !(wrAcc && address == `ACMP_OFS_FLAGS)
      |=> eventFlag[0])
      else $error("flag dropped without software clear");

   chk_status_layout: assert property ( // RL10
      rdReq && address == `ACMP_OFS_STATUS
      |=> readdata[4:0] == `ACMP_STAT_PAD &&
          readdata[7:5] == $past(result) && !waitrequest)
      else $error("status read data wrong");

   chk_small_pkg_routes: assert property ( // RL9
      smallPkg && $past(smallPkg) |-> !negRoute[`ACMP_RT_PIN_C] &&
         !negRoute[`ACMP_NROUTE + `ACMP_RT_PIN_C] &&
         !negRoute[`ACMP_NROUTE + `ACMP_RT_EXTRA])
      else $error("route to an absent pin");

   chk_pin_direction: assert property ( // RL16
      portDirection[2] |=> !pinDrive[2])
      else $error("pin driven while direction is input");

   chk_drive_needs_oe: assert property ( // RL2 RL16
      !$past(pinSelect[2]) |-> !pinDrive[2])
      else $error("pin driven while output routing is off");

   chk_idle_wait: assert property (
      !(read || write) |=> waitrequest)
      else $error("waitrequest low without a request");

   chk_masked_write: assert property (
      write && !byteenable[0]
      |=> $stable(ctrl[0]) && $stable(ctrl[1]) && $stable(ctrl[2]))
      else $error("control changed by a masked write");

   chk_ctrl_two_write: assert property ( // RL1
      wrAcc && address == `ACMP_OFS_CTRL2
      |=> ctrl[1] == $past(writedata[7:0]))
      else $error("control two not taken from write");

   chk_ctrl_read: assert property (
      rdReq && address == `ACMP_OFS_CTRL1
      |=> readdata[7:0] == $past(ctrl[0]) && readdata[31:8] == '0)
      else $error("control one read data wrong");

   chk_readdata_hold: assert property (
      !rdReq |=> $stable(readdata))
      else $error("read data changed without a read");

   chk_flag_read: assert property ( // RL15
      rdReq && address == `ACMP_OFS_FLAGS
      |=> readdata[`ACMP_NCOMP-1:0] == $past(eventFlag))
      else $error("flag read data wrong");

   chk_flag_write_set: assert property ( // RL15
      wrAcc && address == `ACMP_OFS_FLAGS && writedata[0]
      |=> eventFlag[0])
      else $error("writing one did not set the flag");

   chk_flag_write_clear: assert property ( // RL15
      wrAcc && address == `ACMP_OFS_FLAGS && !writedata[0] && !evtPulse[0]
      |=> !eventFlag[0])
      else $error("writing zero did not clear the flag");

   chk_event_sets_flag: assert property ( // RL4 RL15
      evtPulse[0] |=> eventFlag[0])
      else $error("edge event did not set the flag");

   chk_route_onehot: assert property ( // RL7
      $onehot0(negRoute[`ACMP_NROUTE-1:0]) &&
      $onehot0(negRoute[2*`ACMP_NROUTE-1:`ACMP_NROUTE]) &&
      $onehot0(negRoute[3*`ACMP_NROUTE-1:2*`ACMP_NROUTE]))
      else $error("more than one minus input switch closed");

   chk_route_off: assert property ( // RL1
      !$past(compEnable[0]) |-> negRoute[`ACMP_NROUTE-1:0] == '0)
      else $error("input switch closed on an off comparator");

   chk_bandgap_route: assert property ( // RL7
      $past(compEnable[0]) &&
      $past(ctrl[0][`ACMP_NEG_HI:`ACMP_NEG_LO]) == acmp_pkg::NEG_BANDGAP
      |-> negRoute[`ACMP_RT_BANDGAP])
      else $error("bandgap code did not route the bandgap");

   chk_shared_route: assert property ( // RL8
      $past(compEnable[2]) &&
      $past(ctrl[2][`ACMP_NEG_HI:`ACMP_NEG_LO]) == acmp_pkg::NEG_SHARED
      |-> negRoute[2*`ACMP_NROUTE + `ACMP_RT_SHARED])
      else $error("comparator three did not take the shared pin");

   chk_extra_route: assert property ( // RL8
      $past(compEnable[1]) && !$past(smallPkg) &&
      $past(ctrl[1][`ACMP_NEG_HI:`ACMP_NEG_LO]) == acmp_pkg::NEG_SHARED
      |-> negRoute[`ACMP_NROUTE + `ACMP_RT_EXTRA])
      else $error("comparator two did not take its extra pin");

   cov_flag_rise: cover property ($rose(eventFlag[0]));
   cov_status_read: cover property (
      rdReq && address == `ACMP_OFS_STATUS ##1 !waitrequest);
   cov_any_write: cover property (anyArm[0]);
   cov_extra_route: cover property (negRoute[`ACMP_NROUTE + `ACMP_RT_EXTRA]);
endmodule // analog_comparator_control

//--- design/acmp_regs.svh
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH
// Operation
// RL1 - a comparator works only while control bit 7 is set
// RL2 - control bit 6 routes the result to the comparator's output pin
// RL3 - control bit 5 inverts the result for pin, status and events
// RL4 - bits 4-3 pick events: 00 none, 01 rising, 10 falling, 11 any
// RL5 - writing 11 to the event field sets that comparator's flag once
// RL6 - bit 2 set takes positive input from programmable reference, else pin
// RL7 - bits 1-0: 00 pin b, 01 pin c, 10 shared pin, 11 bandgap
// RL8 - code 10: comparators one and three share a pin, two uses extra pin
// RL9 - on the small package, routes to missing pins are not available
// RL10 - status bits 7-5 hold results three, two, one; bits 4-0 read zero
// RL11 - status bit reads one when plus above minus, reversed when inverted
// RL12 - raw result is high when positive input exceeds negative input
// RL13 - reset clears all control registers, so comparators are off
// RL14 - edge detection acts on the result after inversion
// RL15 - flags stay set until cleared; writing one sets a flag
// RL16 - pin direction still gates whether the output pin is driven
// RL17 - raw results pass two flip-flops before status and edge logic
// RL18 - a disabled comparator makes no events; enabling makes no edge
`define ACMP_NCOMP      3
`define ACMP_ADDR_W     5
`define ACMP_OFS_CTRL1  5'h00
`define ACMP_OFS_CTRL2  5'h04
`define ACMP_OFS_CTRL3  5'h08
`define ACMP_OFS_STATUS 5'h0C
`define ACMP_OFS_FLAGS  5'h10
`define ACMP_BIT_EN     7
`define ACMP_BIT_OE     6
`define ACMP_BIT_POL    5
`define ACMP_EVT_HI     4
`define ACMP_EVT_LO     3
`define ACMP_BIT_REF    2
`define ACMP_NEG_HI     1
`define ACMP_NEG_LO     0
`define ACMP_CTRL_RST   8'h00
`define ACMP_FLAG_RST   3'h0
`define ACMP_STAT_PAD   5'h00
`define ACMP_NROUTE     5
`define ACMP_RT_PIN_B   0
`define ACMP_RT_PIN_C   1
`define ACMP_RT_SHARED  2
`define ACMP_RT_EXTRA   3
`define ACMP_RT_BANDGAP 4
`define ACMP_CMP_ONE    0
`define ACMP_CMP_TWO    1
`endif

//--- design/acmp_pkg.sv
package acmp_pkg;
   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_ANY  = 2'h3
   } edge_sel_t;
   typedef enum logic [1:0] {
      NEG_PIN_B   = 2'h0,
      NEG_PIN_C   = 2'h1,
      NEG_SHARED  = 2'h2,
      NEG_BANDGAP = 2'h3
   } neg_sel_t;
endpackage

//--- design/acmp_sync.sv
`timescale 1ns/1ns
module acmp_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage;

   // first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         stage <= '0;
         dout  <= '0;
      end else begin
         stage <= din; // RL17
         dout  <= stage; // RL17
      end
   end

   chk_two_stage_delay: assert property ( // RL17
      @(posedge sys_clk) disable iff (!rstn)
      $past(rstn, 2) && $past(rstn) |-> dout == $past(din, 2))
      else $error("synchroniser delay is not two cycles");
endmodule // acmp_sync

//--- design/acmp_event.sv
`timescale 1ns/1ns
module acmp_event (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic              syncResult,
   input  wire logic              enable,
   input  wire logic              invert,
   input  acmp_pkg::edge_sel_t    edgeSel,
   output logic                   result,
   output logic                   evtPulse
);
   logic armed;
   logic cur;
   logic rise;
   logic fall;
   logic next_armed;
   logic next_result;
   logic next_evtPulse;

   always_comb begin
      cur = syncResult ^ invert; // RL3 RL11 RL12
      next_armed = enable;
      next_result = enable ? cur : 1'b0; // RL1
      // first enabled cycle only loads the reference value
      rise = armed & enable & ~result & cur; // RL14 RL18
      fall = armed & enable & result & ~cur; // RL14 RL18
      unique case (edgeSel) // RL4
         acmp_pkg::EDGE_NONE: next_evtPulse = 1'b0;
         acmp_pkg::EDGE_RISE: next_evtPulse = rise;
         acmp_pkg::EDGE_FALL: next_evtPulse = fall;
         acmp_pkg::EDGE_ANY:  next_evtPulse = rise | fall;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         armed    <= 1'b0;
         result   <= 1'b0;
         evtPulse <= 1'b0;
      end else begin
         armed    <= next_armed;
         result   <= next_result;
         evtPulse <= next_evtPulse;
      end
   end

   chk_no_disabled_event: assert property ( // RL18
      @(posedge sys_clk) disable iff (!rstn)
      !$past(enable) |-> !evtPulse)
      else $error("event from a disabled comparator");

   chk_never_mode: assert property ( // RL4
      @(posedge sys_clk) disable iff (!rstn)
      $past(edgeSel) == acmp_pkg::EDGE_NONE |-> !evtPulse)
      else $error("event while event field is off");

   chk_rise_only: assert property ( // RL14
      @(posedge sys_clk) disable iff (!rstn)
      evtPulse && $past(edgeSel) == acmp_pkg::EDGE_RISE
      |-> result && !$past(result))
      else $error("rising event without a rising result");

   cov_fall_event: cover property (
      @(posedge sys_clk) disable iff (!rstn)
      evtPulse && $past(edgeSel) == acmp_pkg::EDGE_FALL);
endmodule // acmp_event

//--- testbench/acmp_analog_model.sv
`timescale 1ns/1ns
module acmp_analog_model (
   input  wire logic [2:0]  posRefSelect,
   input  wire logic [14:0] negRoute,
   input  wire logic [7:0]  pinLevel,
   input  wire logic [7:0]  refLevel,
   input  wire logic [39:0] routeLevel,
   output logic      [2:0]  rawResult
);
   // with no route selected the minus input rests on pin b, so turning
   // a comparator on with pin b selected does not glitch its result
   always_comb begin
      logic [7:0] plus;
      logic [7:0] minus;
      plus = 8'h00;
      minus = 8'h00;
      rawResult = 3'h0;
      for (int i = 0; i < 3; i++) begin
         plus = posRefSelect[i] ? refLevel : pinLevel;
         minus = routeLevel[7:0];
         for (int r = 0; r < 5; r++) begin
            if (negRoute[i*5+r]) minus = routeLevel[r*8+:8];
         end
         rawResult[i] = plus > minus;
      end
   end
endmodule // acmp_analog_model

//--- testbench/analog_comparator_control_tb.sv
`timescale 1ns/1ns
`include "acmp_regs.svh"
module analog_comparator_control_tb;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [2:0]  rawResult, compEnable, posRefSelect, pinSelect;
   logic [2:0]  pinValue, pinDrive, eventFlag;
   logic [2:0]  portDirection = 3'h7;
   logic        smallPackage = 1'b0;
   logic [14:0] negRoute;
   logic [7:0]  pinLevel = 8'h80;
   logic [7:0]  refLevel = 8'h00;
   logic [39:0] routeLevel = 40'h0;
   logic [31:0] rd;
   int          numErrors = 0;
   int          checked = 0;

   always #4 sys_clk = ~sys_clk;

   analog_comparator_control dut (
      .sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .rawResult(rawResult), .smallPackage(smallPackage),
      .portDirection(portDirection), .compEnable(compEnable),
      .posRefSelect(posRefSelect), .negRoute(negRoute),
      .pinSelect(pinSelect), .pinValue(pinValue), .pinDrive(pinDrive),
      .eventFlag(eventFlag));

   acmp_analog_model analog (
      .posRefSelect(posRefSelect), .negRoute(negRoute),
      .pinLevel(pinLevel), .refLevel(refLevel), .routeLevel(routeLevel),
      .rawResult(rawResult));

   task closeOut;
      $display("checked %0d mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string what);
      checked++;
      if (seen !== exp) begin
         numErrors++;
         $display("unexpected at %0t: %s seen %0h expected %0h",
                  $time, what, seen, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // request held until waitrequest is sampled low, bounded wait
   task busCycle(input logic [4:0] a, input logic wr, input logic [7:0] d,
                 input logic [3:0] be);
      int n;
      @(posedge sys_clk);
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= be;
      read <= ~wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (waitrequest !== 1'b0) begin
         numErrors++;
         $display("unexpected at %0t: bus never answered", $time);
         closeOut;
      end
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d);
      busCycle(a, 1'b1, d, 4'h1);
   endtask

   task rdc(input logic [4:0] a, input logic [31:0] exp, input string what);
      busCycle(a, 1'b0, 8'h00, 4'h1);
      check(rd, exp, what);
   endtask

   task testReset;
      check(32'({compEnable, posRefSelect, pinSelect, pinDrive, pinValue,
             eventFlag}), 32'h0, "outputs");
      check(32'(negRoute), 32'h0, "route");
      for (int a = 0; a < 24; a += 4) rdc(5'(a), 32'h0, "reset");
      $display("test reset done");
   endtask

   task testRegs;
      busCycle(`ACMP_OFS_CTRL2, 1'b1, 8'hA4, 4'hE);
      rdc(`ACMP_OFS_CTRL2, 32'h0, "masked write");
      for (int c = 0; c < 3; c++) begin
         wr(5'(c*4), 8'h84);
         rdc(5'(c*4), 32'h84, "ctrl readback");
      end
      tick(3);
      check(32'(compEnable), 32'h7, "enable");
      check(32'(posRefSelect), 32'h7, "ref select");
      wr(`ACMP_OFS_STATUS, 8'hFF);
      rdc(`ACMP_OFS_STATUS, 32'h0, "status low ref");
      refLevel <= 8'hFF;
      tick(5);
      rdc(`ACMP_OFS_STATUS, 32'hE0, "status high ref");
      for (int c = 0; c < 3; c++) wr(5'(c*4), 8'h00);
      $display("test regs done");
   endtask

   task testRoute;
      logic [4:0] exp;
      logic       miss;
      for (int s = 0; s < 2; s++) begin
         smallPackage <= s[0];
         tick(4);
         for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 4; k++) begin
               wr(5'(c*4), 8'h80 | 8'(k));
               tick(3);
               miss = s == 1 && ((c == 0 && k == 1) ||
                                 (c == 1 && (k == 1 || k == 2)));
               exp = k == 3 ? 5'h10 : (k == 2 && c == 1) ? 5'h08 : 5'(1 << k);
               check(32'(negRoute[c*5+:5]), 32'(miss ? 5'h0 : exp),
                     "route");
            end
            wr(5'(c*4), 8'h00);
         end
      end
      smallPackage <= 1'b0;
      $display("test route done");
   endtask

   task testEvents;
      logic exp;
      for (int p = 0; p < 2; p++) begin
         for (int e = 0; e < 4; e++) begin
            wr(`ACMP_OFS_CTRL1, 8'h00);
            routeLevel[7:0] <= 8'h10;
            tick(5);
            wr(`ACMP_OFS_FLAGS, 8'h00);
            wr(`ACMP_OFS_CTRL1, 8'h80 | 8'(p << 5) | 8'(e << 3));
            tick(6);
            rdc(`ACMP_OFS_FLAGS, {31'h0, e == 3}, "arm flag");
            rdc(`ACMP_OFS_STATUS, {26'h0, ~p[0], 5'h0}, "status");
            wr(`ACMP_OFS_FLAGS, 8'h00);
            routeLevel[7:0] <= 8'hF0;
            tick(6);
            exp = e == 3 || (e == 2 && p == 0) || (e == 1 && p == 1);
            check(32'(eventFlag), {31'h0, exp}, "fall event");
            check(32'(pinValue), {31'h0, p[0]}, "pin value");
            wr(`ACMP_OFS_FLAGS, 8'h00);
            routeLevel[7:0] <= 8'h10;
            tick(6);
            exp = e == 3 || (e == 1 && p == 0) || (e == 2 && p == 1);
            check(32'(eventFlag), {31'h0, exp}, "rise event");
         end
      end
      wr(`ACMP_OFS_CTRL1, 8'h90);
      tick(6);
      wr(`ACMP_OFS_FLAGS, 8'h00);
      wr(`ACMP_OFS_CTRL1, 8'h10);
      tick(6);
      check(32'(eventFlag), 32'h0, "disable event");
      rdc(`ACMP_OFS_STATUS, 32'h0, "disabled status");
      wr(`ACMP_OFS_FLAGS, 8'h05);
      rdc(`ACMP_OFS_FLAGS, 32'h5, "flag write");
      tick(10);
      check(32'(eventFlag), 32'h5, "flag sticky");
      wr(`ACMP_OFS_FLAGS, 8'h00);
      wr(`ACMP_OFS_CTRL1, 8'h00);
      $display("test events done");
   endtask

   task testPins;
      wr(`ACMP_OFS_CTRL3, 8'hC0);
      portDirection <= 3'h3;
      tick(5);
      check(32'({pinSelect, pinDrive, pinValue}), 32'h124, "pin on");
      rdc(`ACMP_OFS_STATUS, 32'h80, "status three");
      portDirection <= 3'h7;
      tick(3);
      check(32'({pinSelect, pinDrive}), 32'h20, "pin input");
      wr(`ACMP_OFS_CTRL3, 8'h80);
      tick(3);
      check(32'({pinSelect, pinDrive}), 32'h0, "pin off");
      wr(`ACMP_OFS_CTRL3, 8'h00);
      $display("test pins done");
   endtask

   initial begin
      tick(8);
      rstn <= 1'b1;
      tick(2);
      testReset;
      testRegs;
      testRoute;
      testEvents;
      testPins;
      closeOut;
   end
endmodule // analog_comparator_control_tb
